// >>> rtl/dms_sequencer.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// diagnose microstep sequencer with apb register access
module dms_sequencer
  import dms_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // main storage port
  output logic             mem_req,
  output logic             mem_we,
  output logic [23:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // microprogram store control
  output logic [11:0]      microprogram_address_register,
  output logic             uload,
  output logic             cpu_clk_adv,
  output logic             chan_clk_inh,
  output logic             io_mode,
  output logic             sto_enable,
  output logic             diag_busy
);
  import dms_pkg::*;

  dms_state_type state_ff;
  dms_state_type nxt_state;
  logic [31:0]   opadr_ff;
  logic [7:0]    imm_ff;
  logic          chinh_ff;
  logic          go_pulse;
  logic [31:0]   storage_data_register_ff;
  logic [23:0]   lcw_adr_ff;
  logic [2:0]    cnt_ff;
  logic [11:0]   uadr_ff;
  logic          uload_ff;
  logic          adv_ff;
  logic          chain_q;
  logic          step_q;
  logic          iom_q;
  logic          sen_q;
  logic          stat_load;
  logic          v_iom;
  logic          v_sen;
  logic          v_chain;
  logic          v_step;
  logic          wr_en;
  logic          addr_ok;
  logic [7:0]    imm_go;

  // apb write strobe and answer, always zero wait
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // address decode of the six mapped words
  always_comb begin
    case (paddr)
      DMS_OFS_CTRL:   addr_ok = 1'b1;
      DMS_OFS_OPADR:  addr_ok = 1'b1;
      DMS_OFS_STATUS: addr_ok = 1'b1;
      DMS_OFS_UADR:   addr_ok = 1'b1;
      DMS_OFS_SDATA:  addr_ok = 1'b1;
      DMS_OFS_LCWADR: addr_ok = 1'b1;
      default:        addr_ok = 1'b0;
    endcase
  end

  // immediate byte of the start write itself, so one write carries a whole diagnose
  assign imm_go   = pwdata[DMS_CTRL_IMM_LO +: 8];
  assign go_pulse = wr_en && (paddr == DMS_OFS_CTRL) && pwdata[DMS_CTRL_GO] && (state_ff == DMS_IDLE
                    || state_ff == DMS_DONE);

  // operand address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opadr_ff <= 32'h0;
    end else if (wr_en && paddr == DMS_OFS_OPADR) begin
      opadr_ff <= pwdata;
    end
  end

  // immediate byte register, kept for readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm_ff <= 8'h0;
    end else if (wr_en && paddr == DMS_OFS_CTRL) begin
      imm_ff <= imm_go;
    end
  end

  // channel interface inhibit bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chinh_ff <= 1'b0;
    end else if (wr_en && paddr == DMS_OFS_CTRL) begin
      chinh_ff <= pwdata[DMS_CTRL_CHINH];
    end
  end

  // linkage word address, stepped past each linkage word taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcw_adr_ff <= 24'h0;
    end else if (wr_en && paddr == DMS_OFS_LCWADR) begin
      lcw_adr_ff <= pwdata[23:0];
    end else if (state_ff == DMS_LOAD) begin
      lcw_adr_ff <= lcw_adr_ff + DMS_WORD_BYTES;  // next linkage word
    end
  end

  // channel clock inhibit straight from interface bit
  assign chan_clk_inh = chinh_ff;

  // read mux, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        DMS_OFS_CTRL:   prdata <= {16'h0, imm_ff, 6'h0, chinh_ff, 1'b0};
        DMS_OFS_OPADR:  prdata <= opadr_ff;
        DMS_OFS_STATUS: prdata <= {21'h0, state_ff, cnt_ff, iom_q, sen_q, chain_q, step_q, diag_busy};
        DMS_OFS_UADR:   prdata <= {20'h0, uadr_ff};
        DMS_OFS_SDATA:  prdata <= storage_data_register_ff;
        DMS_OFS_LCWADR: prdata <= {8'h0, lcw_adr_ff};
        default:        prdata <= 32'h0;
      endcase
    end
  end

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DMS_IDLE, DMS_DONE: begin
        if (go_pulse) nxt_state = DMS_STORE;
      end
      DMS_STORE: begin
        if (mem_ack) nxt_state = DMS_STEP;
      end
      DMS_STEP: begin
        if (!step_q || cnt_ff == 3'h0) begin
          nxt_state = chain_q ? DMS_FETCH : DMS_DONE;
        end
      end
      DMS_FETCH: begin
        if (mem_ack) nxt_state = DMS_LOAD;
      end
      DMS_LOAD:  nxt_state = DMS_STEP;
      default:   nxt_state = DMS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= DMS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // storage data register assembly and linkage capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storage_data_register_ff <= 32'h0;
    end else if (go_pulse) begin
      storage_data_register_ff <= {imm_go, opadr_ff[23:0]};
    end else if (state_ff == DMS_FETCH && mem_ack) begin
      storage_data_register_ff <= mem_rdata;
    end
  end

  // main storage requests: store to the fixed word, fetch from the linkage address
  always_comb begin
    mem_req  = 1'b0;
    mem_we   = 1'b0;
    mem_addr = lcw_adr_ff;
    case (state_ff)
      DMS_STORE: begin
        mem_req  = 1'b1;
        mem_we   = 1'b1;
        mem_addr = DMS_DIAG_LOC;
      end
      DMS_FETCH: begin
        mem_req  = 1'b1;
      end
      default: ;
    endcase
  end

  // write data straight from the storage data register
  assign mem_wdata = storage_data_register_ff;

  // stat load values from operand address and immediate, or from linkage word
  always_comb begin
    stat_load = 1'b0;
    v_iom     = 1'b0;
    v_sen     = 1'b0;
    v_chain   = 1'b0;
    v_step    = 1'b0;
    if (go_pulse) begin
      stat_load = 1'b1;
      v_iom     = opadr_ff[DMS_OP_IOMODE];
      v_sen     = imm_go[DMS_IM_SEN];
      v_chain   = imm_go[DMS_IM_CHAIN];
      v_step    = imm_go[DMS_IM_STEP];
    end else if (state_ff == DMS_LOAD) begin
      stat_load = 1'b1;
      v_iom     = storage_data_register_ff[DMS_LW_IOMODE];
      v_sen     = storage_data_register_ff[DMS_LW_SEN];
      v_chain   = storage_data_register_ff[DMS_LW_CHAIN];
      v_step    = storage_data_register_ff[DMS_LW_STEP];
    end
  end

  // i/o mode stat
  dms_stat_reg u_iom (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (stat_load),
    .din     (v_iom),
    .q       (iom_q)
  );

  // storage enable stat
  dms_stat_reg u_sen (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (stat_load),
    .din     (v_sen),
    .q       (sen_q)
  );

  // chain stat
  dms_stat_reg u_chn (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (stat_load),
    .din     (v_chain),
    .q       (chain_q)
  );

  // stepping stat
  dms_stat_reg u_stp (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (stat_load),
    .din     (v_step),
    .q       (step_q)
  );

  // step counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= DMS_CNT_RST;
    end else if (go_pulse) begin
      cnt_ff <= imm_go[DMS_IM_CNT_HI -: 3];
    end else if (state_ff == DMS_LOAD) begin
      cnt_ff <= storage_data_register_ff[DMS_LW_CNT_HI -: 3];
    end else if (state_ff == DMS_STEP && step_q && cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;  // one cycle per decrement
    end
  end

  // microprogram address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uadr_ff <= DMS_UADR_RST;
    end else if (go_pulse) begin
      uadr_ff <= opadr_ff[DMS_OP_UA_HI -: 12];
    end else if (state_ff == DMS_LOAD) begin
      uadr_ff <= storage_data_register_ff[DMS_LW_UA_HI -: 12];
    end
  end

  // clock advance pulse, one cycle per decrement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_ff <= 1'b0;
    end else begin
      adv_ff <= (state_ff == DMS_STEP) && step_q && (cnt_ff != 3'h0);
    end
  end

  // address load strobe, one cycle after the store answer or the load state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uload_ff <= 1'b0;
    end else begin
      uload_ff <= (state_ff == DMS_STORE && mem_ack) || (state_ff == DMS_LOAD);
    end
  end

  assign microprogram_address_register = uadr_ff;
  assign uload       = uload_ff;
  assign cpu_clk_adv = adv_ff;
  assign io_mode     = iom_q;
  assign sto_enable  = sen_q;
  assign diag_busy   = (state_ff != DMS_IDLE) && (state_ff != DMS_DONE);
endmodule : dms_sequencer

// >>> inc/dms_pkg.sv
// package: constants, register map and types for the diagnose microstep sequencer
package dms_pkg;
  // storage location for the assembled word
  localparam logic [23:0] DMS_DIAG_LOC     = 24'h000080;
  // apb register byte offsets
  localparam logic [7:0]  DMS_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  DMS_OFS_OPADR    = 8'h04;
  localparam logic [7:0]  DMS_OFS_STATUS   = 8'h08;
  localparam logic [7:0]  DMS_OFS_UADR     = 8'h0c;
  localparam logic [7:0]  DMS_OFS_SDATA    = 8'h10;
  localparam logic [7:0]  DMS_OFS_LCWADR   = 8'h14;
  // control register bit positions
  localparam int          DMS_CTRL_GO      = 0;
  localparam int          DMS_CTRL_CHINH   = 1;
  localparam int          DMS_CTRL_IMM_LO  = 8;
  // operand address fields, bit 0 is the msb as in the word layout
  localparam int          DMS_OP_IOMODE    = 31 - 8;
  localparam int          DMS_OP_UA_HI     = 31 - 20;
  // immediate fields, byte of 8 bits, bit 0 is msb
  localparam int          DMS_IM_CNT_HI    = 7 - 1;
  localparam int          DMS_IM_SEN       = 7 - 5;
  localparam int          DMS_IM_CHAIN     = 7 - 6;
  localparam int          DMS_IM_STEP      = 7 - 7;
  // linkage control word fields
  localparam int          DMS_LW_UA_HI     = 31 - 19;
  localparam int          DMS_LW_CNT_HI    = 31 - 0;
  localparam int          DMS_LW_SEN       = 31 - 4;
  localparam int          DMS_LW_CHAIN     = 31 - 5;
  localparam int          DMS_LW_STEP      = 31 - 6;
  localparam int          DMS_LW_IOMODE    = 31 - 7;
  // word step to the following storage word
  localparam logic [23:0] DMS_WORD_BYTES   = 24'h000004;
  // reset values
  localparam logic [11:0] DMS_UADR_RST     = 12'h000;
  localparam logic [2:0]  DMS_CNT_RST      = 3'h0;

  typedef enum logic [2:0] {
    DMS_IDLE   = 3'b000,
    DMS_STORE  = 3'b001,
    DMS_STEP   = 3'b011,
    DMS_FETCH  = 3'b010,
    DMS_LOAD   = 3'b110,
    DMS_DONE   = 3'b111
  } dms_state_type;
endpackage : dms_pkg

// >>> rtl/dms_stat_reg.sv
`timescale 1ns/1ns
// one loadable stat bit with reset
module dms_stat_reg (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // load control
  input  wire logic load,
  input  wire logic din,
  // held value
  output logic      q
);
  // loads on request, holds otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (load) begin
      q <= din;
    end
  end
endmodule : dms_stat_reg

// >>> dv/dms_mem_model.sv
// storage model answering store and fetch requests of the sequencer
`timescale 1ns/1ns
module dms_mem_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // storage port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // answer delay in cycles
  input  wire logic [3:0]  lat
);
  logic [31:0] mem_ff [0:63];
  logic [3:0]  wait_ff;
  // answer lat+1 cycles after the request starts; read data scrambled outside the answer cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_ff   <= 4'h0;
      mem_rdata <= 32'h5a5a5a5a;
    end else if (mem_req && !mem_ack && wait_ff >= lat) begin
      mem_ack   <= 1'b1;
      wait_ff   <= 4'h0;
      mem_rdata <= mem_we ? ~mem_rdata : mem_ff[mem_addr[7:2]];
    end else begin
      mem_ack   <= 1'b0;
      wait_ff   <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_ack && mem_we) mem_ff[mem_addr[7:2]] <= mem_wdata;
    end
  end
endmodule : dms_mem_model

// >>> dv/dms_sequencer_monitor.sv
// checker watching the sequencer ports
`timescale 1ns/1ns
module dms_sequencer_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // storage port
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata,
  // microprogram side
  input wire logic [11:0] microprogram_address_register,
  input wire logic        uload,
  input wire logic        cpu_clk_adv,
  input wire logic        io_mode,
  input wire logic        sto_enable,
  input wire logic        diag_busy
);
  logic [11:0] ua_ff;
  logic [3:0]  n_ff, c_ff;
  logic        io_ff, se_ff, ch_ff;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // expected fields latched from the word stored or fetched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ua_ff, n_ff, io_ff, se_ff, ch_ff} <= '0;
    end else if (mem_req && mem_ack) begin
      {ua_ff, io_ff, se_ff, ch_ff} <= mem_we ? {mem_wdata[11:0], mem_wdata[23], mem_wdata[26], mem_wdata[25]}
                                             : {mem_rdata[12:1], mem_rdata[24], mem_rdata[27], mem_rdata[26]};
      n_ff <= mem_we ? (mem_wdata[24] ? {1'b0, mem_wdata[30:28]} : 4'h0)
                     : (mem_rdata[25] ? {1'b0, mem_rdata[31:29]} : 4'h0);
    end
  end
  // clock advance pulses since the last storage answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c_ff <= 4'h0;
    else if (mem_req && mem_ack) c_ff <= 4'h0;
    else if (cpu_clk_adv) c_ff <= c_ff + 4'h1;
  end
  a_store_loc: assert property (mem_req && mem_we |-> mem_addr == 24'h000080)
    else $error("store not aimed at the diagnose location");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("storage request dropped or changed before answer");
  a_uaddr_load: assert property (uload |-> microprogram_address_register == ua_ff)
    else $error("microprogram address not taken from the word");
  a_stat_load: assert property (uload |-> io_mode == io_ff && sto_enable == se_ff)
    else $error("mode or storage enable stat wrong");
  a_step_count: assert property ((mem_req && mem_ack && !mem_we) || $fell(diag_busy)
                                 |-> c_ff + 4'(cpu_clk_adv) == n_ff)
    else $error("clock advance count differs from step count");
  a_chain_gate: assert property ($rose(mem_req) && !mem_we |-> ch_ff)
    else $error("linkage fetch without chain stat");
  a_end_no_chain: assert property ($fell(diag_busy) |-> !ch_ff)
    else $error("stepping ended with chain stat set");
  a_idle_quiet: assert property (!diag_busy && !$past(diag_busy) |-> !cpu_clk_adv && !mem_req && !uload)
    else $error("activity while idle");
endmodule : dms_sequencer_monitor
bind dms_sequencer dms_sequencer_monitor dms_sequencer_monitor_inst (.pclk(pclk), .presetn(presetn),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .microprogram_address_register(microprogram_address_register), .uload(uload),
  .cpu_clk_adv(cpu_clk_adv), .io_mode(io_mode), .sto_enable(sto_enable), .diag_busy(diag_busy));

// >>> dv/tb_top.sv
// testbench: diagnose runs started over apb against the storage model
`timescale 1ns/1ns
module tb_top;
  import dms_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        mem_req, mem_we, mem_ack, uload, cpu_clk_adv, chan_clk_inh, io_mode, sto_enable, diag_busy;
  logic [7:0]  paddr;
  logic [11:0] microprogram_address_register;
  logic [23:0] mem_addr;
  logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, rd;
  logic [3:0]  lat;
  int          err_count, checks, pulses;
  dms_sequencer dms_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .microprogram_address_register(microprogram_address_register), .uload(uload),
    .cpu_clk_adv(cpu_clk_adv), .chan_clk_inh(chan_clk_inh), .io_mode(io_mode), .sto_enable(sto_enable),
    .diag_busy(diag_busy));
  dms_mem_model dms_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // count clock advance pulses
  always @(posedge pclk) begin
    if (cpu_clk_adv === 1'b1) pulses = pulses + 1;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin err_count++; results(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one diagnose run, checking pulses, stored word and final state
  task automatic run(input logic [23:0] op, input logic [7:0] im, input int n, input logic [11:0] ua,
                     input logic io, input logic se);
    int i;
    pulses = 0;
    apb(1'b1, DMS_OFS_OPADR, {8'h00, op});
    apb(1'b1, DMS_OFS_CTRL, {16'h0000, im, 8'h03});
    for (i = 0; i < 400 && diag_busy !== 1'b0; i++) begin @(posedge pclk); #1; end
    if (i >= 400) begin err_count++; results(); end
    repeat (3) @(posedge pclk);
    chk(32'(pulses), 32'(n));
    chk(dms_mem_model_inst.mem_ff[32], {im, op});
    chk({20'h0, microprogram_address_register}, {20'h0, ua});
    apb(1'b0, DMS_OFS_UADR, 32'h0);
    chk(rd, {20'h0, ua});
    chk({30'h0, io_mode, sto_enable}, {30'h0, io, se});
    chk({31'h0, chan_clk_inh}, 32'h1);
    $display("diagnose run done");
  endtask : run
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00; pwdata = 32'h0; lat = 4'h1; err_count = 0; checks = 0; pulses = 0;
    dms_mem_model_inst.mem_ff[36] = 32'h46000246;
    dms_mem_model_inst.mem_ff[37] = 32'heb001ffe;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, DMS_OFS_CTRL, 32'h00000002);
    chk({31'h0, chan_clk_inh}, 32'h1);
    $display("register test done");
    run(24'h800abc, 8'h55, 5, 12'habc, 1'b1, 1'b1);
    lat <= 4'h5;
    apb(1'b1, DMS_OFS_LCWADR, 32'h00000090);
    run(24'h000010, 8'h03, 9, 12'hfff, 1'b1, 1'b1);
    apb(1'b0, DMS_OFS_LCWADR, 32'h0);
    chk(rd, 32'h00000098);
    run(24'h000fff, 8'h70, 0, 12'hfff, 1'b0, 1'b0);
    apb(1'b1, DMS_OFS_CTRL, 32'h0);
    chk({31'h0, chan_clk_inh}, 32'h0);
    results();
  end
endmodule : tb_top
